//--- common/dabt_pkg.sv
// Constants of the distortion alarm stage: register map, fields, timing.
// Assumes a 200 MHz system clock and 32-bit APB register access.
package dabt_pkg;
  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_MHZ        = 200;
  localparam int MS_US          = 1000;   // Time stamp step, 1 ms
  localparam int MS_CYCLES      = MS_US * CLK_MHZ;
  localparam int DLY_STEP_MS    = 5;      // Delay resolution, 0.005 s
  localparam int BLK_LEAD_MS    = 5;      // Block lead time of the source

  // ****************************************************
  // Widths and defaults
  // ****************************************************
  localparam int THD_W          = 14;     // Distortion in 0.01 % units
  localparam int DLY_W          = 19;     // Delay in 5 ms steps
  localparam int ELAP_W         = 21;     // Elapsed ms of the alarm timer
  localparam int SG_W           = 3;      // Eight setting groups
  localparam int EV_W           = 3;
  localparam int REC_DEPTH      = 12;
  localparam int REC_AW         = 4;
  localparam int REC_W          = 80;
  localparam logic [THD_W-1:0] THR_RST  = 14'h03e8;   // 10.00 %
  localparam logic [DLY_W-1:0] DLY_RST  = 19'h007d0;  // 10.000 s
  localparam logic [6:0]       HYST_PCT = 7'h61;      // Reset ratio 97 %
  localparam logic [6:0]       FULL_PCT = 7'h64;      // 100 %

  // ****************************************************
  // Register byte offsets
  // ****************************************************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_THR    = 8'h04;
  localparam logic [7:0] A_DLY    = 8'h08;
  localparam logic [7:0] A_STAT   = 8'h0c;
  localparam logic [7:0] A_TIME   = 8'h10;
  localparam logic [7:0] A_RSEL   = 8'h14;
  localparam logic [7:0] A_RTIME  = 8'h18;
  localparam logic [7:0] A_RINFO  = 8'h1c;
  localparam logic [7:0] A_RL12   = 8'h20;
  localparam logic [7:0] A_RL3    = 8'h24;

  // ****************************************************
  // Control fields
  // ****************************************************
  localparam int C_EN    = 0;             // alarm_path_enable
  localparam int C_FMODE = 1;             // Test forcing mode
  localparam int C_FSW   = 2;             // Software block switch
  localparam int C_FON   = 4;             // Write ON events
  localparam int C_FOFF  = 5;             // Write OFF events
  localparam int C_SG    = 8;             // Active setting group
  localparam logic [31:0] CTRL_RST = 32'h0000_0031;

  // ****************************************************
  // Event identities (distortion_event_group)
  // ****************************************************
  localparam int NEV = 6;
  localparam logic [EV_W-1:0] EV_START_ON  = 3'h0;
  localparam logic [EV_W-1:0] EV_START_OFF = 3'h1;
  localparam logic [EV_W-1:0] EV_ALARM_ON  = 3'h2;
  localparam logic [EV_W-1:0] EV_ALARM_OFF = 3'h3;
  localparam logic [EV_W-1:0] EV_BLK_ON    = 3'h4;
  localparam logic [EV_W-1:0] EV_BLK_OFF   = 3'h5;

  // Function state
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_START = 3'b010,
    ST_BLK   = 3'b100
  } dabt_state_t;
endpackage

//--- rtl/dabt_rec_mem.sv
// Record store of the alarm stage: a small synchronous memory.
// Assumes one clock; read data appear one edge after the address.
`timescale 1ns/1ps
module dabt_rec_mem #(
  parameter int W  = dabt_pkg::REC_W,
  parameter int D  = dabt_pkg::REC_DEPTH,
  parameter int AW = dabt_pkg::REC_AW
) (
  // Clock
  input  wire logic          i_sys_clk,
  // Write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  // Read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [W-1:0]  o_rdata
);
  logic [W-1:0] mem [D];

  // Write store
  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Registered read, zero past the last entry
  always_ff @(posedge i_sys_clk) begin
    if (i_raddr < AW'(D)) begin
      o_rdata <= mem[i_raddr];
    end else begin
      o_rdata <= '0;
    end
  end
endmodule // dabt_rec_mem

//--- rtl/dabt_top.sv
// Alarm, block check and delay timer of a phase voltage distortion
// monitor, with events and a rolling record store behind APB.
// Assumes phase values, tick and block input come from same-clock logic.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module dabt_top #(
  parameter int MS_CYC = dabt_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst,
  // APB slave
  input  wire logic                       i_psel,
  input  wire logic                       i_penable,
  input  wire logic                       i_pwrite,
  input  wire logic [7:0]                 i_paddr,
  input  wire logic [31:0]                i_pwdata,
  output logic      [31:0]                o_prdata,
  output logic                            o_pready,
  output logic                            o_pslverr,
  // Measurement and block inputs
  input  wire logic                       i_cycle_tick,
  input  wire logic                       i_block,
  input  wire logic [dabt_pkg::THD_W-1:0] i_thd_l1,
  input  wire logic [dabt_pkg::THD_W-1:0] i_thd_l2,
  input  wire logic [dabt_pkg::THD_W-1:0] i_thd_l3,
  // Function outputs
  output logic                            o_pickup,
  output logic                            o_start,
  output logic                            o_alarm,
  output logic                            o_blocked,
  output logic                            o_disp_notify,
  // Event port to the main event buffer
  output logic                            o_evt_valid,
  output logic [dabt_pkg::EV_W-1:0]       o_evt_id,
  output logic [31:0]                     o_evt_time,
  output logic [dabt_pkg::THD_W-1:0]      o_evt_l1,
  output logic [dabt_pkg::THD_W-1:0]      o_evt_l2,
  output logic [dabt_pkg::THD_W-1:0]      o_evt_l3,
  output logic [2:0]                      o_evt_fault,
  output logic [dabt_pkg::SG_W-1:0]       o_evt_sg
);
  localparam int TW = dabt_pkg::THD_W;
  localparam int MW = $clog2(MS_CYC);
  localparam int ELAP_W = dabt_pkg::ELAP_W;

  // ****************************************************
  // Declarations
  // ****************************************************
  logic [31:0]                ctrl_r;
  logic [TW-1:0]              thr_r;
  logic [dabt_pkg::DLY_W-1:0] dly_r;
  logic [31:0]                time_r;
  logic [dabt_pkg::REC_AW-1:0] rsel_r;
  logic [MW-1:0]              ms_cnt_r;
  logic                       ms_tick;
  logic [MW-1:0]              tmr_cnt_r;
  logic                       tmr_tick;
  logic                       blk_r;
  logic                       blk_src;
  logic                       pick_r;
  logic                       pick_nxt;
  logic [2:0]                 over;
  logic [2:0]                 under;
  logic [TW-1:0]              ph [3];
  logic [TW-1:0]              cap_r [3];
  logic [2:0]                 fault_r;
  dabt_pkg::dabt_state_t      st_r;
  dabt_pkg::dabt_state_t      st_nxt;
  logic [dabt_pkg::ELAP_W-1:0] elap_r;
  logic [dabt_pkg::ELAP_W-1:0] dly_ms;
  logic                       alarm_r;
  logic [2:0]                 sig;
  logic [2:0]                 sig_q_r;
  logic [dabt_pkg::NEV-1:0]   pend_r;
  logic [dabt_pkg::NEV-1:0]   pend_set;
  logic [dabt_pkg::NEV-1:0]   pend_clr;
  logic                       emit;
  logic [dabt_pkg::EV_W-1:0]  emit_id;
  logic                       emit_on;
  logic                       pass;
  logic [dabt_pkg::REC_AW-1:0] wptr_r;
  logic [dabt_pkg::REC_AW-1:0] fill_r;
  logic [dabt_pkg::REC_W-1:0] rec_wdata;
  logic [dabt_pkg::REC_W-1:0] rec_rdata;
  logic                       wr_acc;
  logic                       rd_setup;
  logic                       hit;
  logic [31:0]                rd_mux;
  logic                       en;

  // Below 97 % of threshold: v*100 < thr*97
  function automatic logic below_hyst(input logic [TW-1:0] v,
                                      input logic [TW-1:0] t);
    logic [TW+6:0] a;
    logic [TW+6:0] b;
    a = v * dabt_pkg::FULL_PCT;
    b = t * dabt_pkg::HYST_PCT;
    return a < b;
  endfunction

  // Address decode shared by write and error paths
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      dabt_pkg::A_CTRL, dabt_pkg::A_THR, dabt_pkg::A_DLY,
      dabt_pkg::A_STAT, dabt_pkg::A_TIME, dabt_pkg::A_RSEL,
      dabt_pkg::A_RTIME, dabt_pkg::A_RINFO, dabt_pkg::A_RL12,
      dabt_pkg::A_RL3: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ****************************************************
  // APB register access
  // ****************************************************
  assign o_pready  = 1'b1;
  assign hit       = mapped(i_paddr);
  assign wr_acc    = i_psel & i_penable & i_pwrite & hit;
  assign rd_setup  = i_psel & ~i_penable & ~i_pwrite;
  assign o_pslverr = i_psel & i_penable & ~hit;
  assign en        = ctrl_r[dabt_pkg::C_EN];

  // Control, threshold, delay and record select
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= dabt_pkg::CTRL_RST;
      thr_r  <= dabt_pkg::THR_RST;
      dly_r  <= dabt_pkg::DLY_RST;
      rsel_r <= '0;
    end else if (wr_acc) begin
      case (i_paddr)
        dabt_pkg::A_CTRL: ctrl_r <= i_pwdata;
        dabt_pkg::A_THR:  thr_r  <= i_pwdata[TW-1:0];
        dabt_pkg::A_DLY:  dly_r  <= i_pwdata[dabt_pkg::DLY_W-1:0];
        dabt_pkg::A_RSEL: rsel_r <= i_pwdata[dabt_pkg::REC_AW-1:0];
        default: ;
      endcase
    end
  end

  // Read data mux
  always_comb begin
    rd_mux = '0;
    case (i_paddr)
      dabt_pkg::A_CTRL:  rd_mux = ctrl_r;
      dabt_pkg::A_THR:   rd_mux = 32'(thr_r);
      dabt_pkg::A_DLY:   rd_mux = 32'(dly_r);
      dabt_pkg::A_STAT:  rd_mux = {20'h0_0000, fill_r, 3'h0,
                                   blk_r, pick_r, sig};
      dabt_pkg::A_TIME:  rd_mux = time_r;
      dabt_pkg::A_RSEL:  rd_mux = 32'(rsel_r);
      dabt_pkg::A_RTIME: rd_mux = rec_rdata[79:48];
      dabt_pkg::A_RINFO: rd_mux = 32'(rec_rdata[47:42]);
      dabt_pkg::A_RL12:  rd_mux = {4'h0, rec_rdata[27:0]};
      dabt_pkg::A_RL3:   rd_mux = 32'(rec_rdata[41:28]);
      default:           rd_mux = '0;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= '0;
    end else if (rd_setup) begin
      o_prdata <= rd_mux;
    end
  end

  // ****************************************************
  // Millisecond time base
  // ****************************************************
  assign ms_tick = (ms_cnt_r == MW'(MS_CYC - 1));

  // Millisecond prescaler
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ms_cnt_r <= '0;
    end else if (ms_tick) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      time_r <= '0;
    end else if (wr_acc && i_paddr == dabt_pkg::A_TIME) begin
      time_r <= i_pwdata;
    end else if (ms_tick) begin
      time_r <= time_r + 32'h0000_0001;
    end
  end

  // ****************************************************
  // Pick-up comparator
  // ****************************************************
  assign ph[0] = i_thd_l1;
  assign ph[1] = i_thd_l2;
  assign ph[2] = i_thd_l3;

  for (genvar g = 0; g < 3; g++) begin : g_ph
    assign over[g]  = ph[g] > thr_r;
    assign under[g] = below_hyst(ph[g], thr_r);
  end

  assign pick_nxt = en & (pick_r ? ~(&under) : (|over));

  assign blk_src = ctrl_r[dabt_pkg::C_FMODE] ?
                   ctrl_r[dabt_pkg::C_FSW] : i_block;

  // block and pick-up sampled per cycle
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      blk_r  <= 1'b0;
      pick_r <= 1'b0;
    end else if (i_cycle_tick) begin
      blk_r  <= blk_src;
      pick_r <= pick_nxt;
    end
  end

  // values and fault type at pick-up
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cap_r   <= '{default: '0};
      fault_r <= '0;
    end else if (i_cycle_tick && pick_nxt && !pick_r) begin
      cap_r   <= ph;
      fault_r <= over;
    end
  end

  // ****************************************************
  // Block check state machine
  // ****************************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      dabt_pkg::ST_IDLE: begin
        if (pick_nxt) begin
          st_nxt = blk_src ? dabt_pkg::ST_BLK : dabt_pkg::ST_START;
        end
      end
      dabt_pkg::ST_START: begin
        if (!pick_nxt) begin
          st_nxt = dabt_pkg::ST_IDLE;
        end else if (blk_src) begin
          st_nxt = dabt_pkg::ST_BLK;
        end
      end
      dabt_pkg::ST_BLK: begin
        if (!pick_nxt) begin
          st_nxt = dabt_pkg::ST_IDLE;
        end else if (!blk_src) begin
          st_nxt = dabt_pkg::ST_START;
        end
      end
      default: st_nxt = dabt_pkg::ST_IDLE;
    endcase
  end

  // State update once per processing cycle
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= dabt_pkg::ST_IDLE;
    end else if (i_cycle_tick) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************
  // Definite time alarm delay
  // ****************************************************
  // delay in 5 ms steps
  assign dly_ms = ELAP_W'(dly_r) * ELAP_W'(dabt_pkg::DLY_STEP_MS);
  assign tmr_tick = (tmr_cnt_r == MW'(MS_CYC - 1));

  // Timer prescaler restarts with start, so the delay is never short
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tmr_cnt_r <= '0;
    end else if (st_r != dabt_pkg::ST_START || tmr_tick) begin
      tmr_cnt_r <= '0;
    end else begin
      tmr_cnt_r <= tmr_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      elap_r <= '0;
    end else if (st_r != dabt_pkg::ST_START) begin
      elap_r <= '0;
    end else if (tmr_tick && elap_r < dly_ms) begin
      elap_r <= elap_r + 1'b1;
    end
  end

  // alarm on expiry, cleared with start
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      alarm_r <= 1'b0;
    end else begin
      alarm_r <= (st_r == dabt_pkg::ST_START) && (elap_r >= dly_ms);
    end
  end

  assign o_start   = (st_r == dabt_pkg::ST_START);
  assign o_blocked = (st_r == dabt_pkg::ST_BLK);
  assign o_alarm   = alarm_r;
  assign o_pickup  = pick_r;
  assign sig       = {o_blocked, alarm_r, o_start};

  // ****************************************************
  // Event generation
  // ****************************************************
  // Previous signal levels
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sig_q_r <= '0;
    end else begin
      sig_q_r <= sig;
    end
  end

  // ON and OFF edges, only while enabled
  for (genvar s = 0; s < 3; s++) begin : g_edge
    assign pend_set[2*s]   = en & sig[s] & ~sig_q_r[s];
    assign pend_set[2*s+1] = en & ~sig[s] & sig_q_r[s];
  end

  // Lowest pending event leaves first
  always_comb begin
    emit     = 1'b0;
    emit_id  = '0;
    pend_clr = '0;
    for (int k = dabt_pkg::NEV - 1; k >= 0; k--) begin
      if (pend_r[k]) begin
        emit     = 1'b1;
        emit_id  = dabt_pkg::EV_W'(k);
        pend_clr = dabt_pkg::NEV'(1) << k;
      end
    end
  end

  // Pending events, a new edge wins over the clear
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~pend_clr) | pend_set;
    end
  end

  assign emit_on = ~emit_id[0];
  assign pass = emit_on ? ctrl_r[dabt_pkg::C_FON] :
                          ctrl_r[dabt_pkg::C_FOFF];

  // event with stamp and process data
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_evt_valid   <= 1'b0;
      o_evt_id      <= '0;
      o_evt_time    <= '0;
      o_evt_l1      <= '0;
      o_evt_l2      <= '0;
      o_evt_l3      <= '0;
      o_evt_fault   <= '0;
      o_evt_sg      <= '0;
      o_disp_notify <= 1'b0;
    end else begin
      o_evt_valid   <= emit & pass;
      o_disp_notify <= emit && emit_id == dabt_pkg::EV_BLK_ON;
      if (emit) begin
        o_evt_id    <= emit_id;
        o_evt_time  <= time_r;
        o_evt_l1    <= cap_r[0];
        o_evt_l2    <= cap_r[1];
        o_evt_l3    <= cap_r[2];
        o_evt_fault <= fault_r;
        o_evt_sg    <= ctrl_r[dabt_pkg::C_SG +: dabt_pkg::SG_W];
      end
    end
  end

  // ****************************************************
  // Rolling record store
  // ****************************************************
  // time, event, group, phases
  assign rec_wdata = {time_r, emit_id,
                      ctrl_r[dabt_pkg::C_SG +: dabt_pkg::SG_W],
                      cap_r[2], cap_r[1], cap_r[0]};

  // ring of twelve, ON events only
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wptr_r <= '0;
      fill_r <= '0;
    end else if (emit && emit_on) begin
      if (wptr_r == dabt_pkg::REC_AW'(dabt_pkg::REC_DEPTH - 1)) begin
        wptr_r <= '0;
      end else begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (fill_r != dabt_pkg::REC_AW'(dabt_pkg::REC_DEPTH)) begin
        fill_r <= fill_r + 1'b1;
      end
    end
  end

  // Record memory
  dabt_rec_mem u_mem (
    .i_sys_clk (i_sys_clk),
    .i_we      (emit & emit_on),
    .i_waddr   (wptr_r),
    .i_wdata   (rec_wdata),
    .i_raddr   (rsel_r),
    .o_rdata   (rec_rdata)
  );
endmodule // dabt_top

//--- test/dabt_partner.sv
// Model of the cycle scheduler and blocking matrix beside the stage.
// Assumes the stage clock; block level follows the bench request.
`timescale 1ns/1ps
module dabt_partner #(
  parameter int TICK_CYC = 10
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  // Bench request
  input  wire logic i_want_block,
  // Toward the stage
  output logic      o_cycle_tick,
  output logic      o_block
);
  int tick_cnt;
  // Processing-cycle pulse, one clock in TICK_CYC
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt     <= 0;
      o_cycle_tick <= 1'b0;
    end else begin
      tick_cnt     <= (tick_cnt == TICK_CYC - 1) ? 0 : tick_cnt + 1;
      o_cycle_tick <= (tick_cnt == TICK_CYC - 1);
    end
  end
  // block lead time
  // Bench raises the request well before the delay can expire
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) o_block <= 1'b0;
    else o_block <= i_want_block;
  end
endmodule // dabt_partner

//--- test/dabt_sva.sv
// Port checker of the distortion alarm stage.
// Assumes a bind into dabt_top; one clock domain.
`timescale 1ns/1ps
module dabt_sva #(
  parameter int MS_CYC = 20
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Stage inputs
  input wire logic i_cycle_tick,
  input wire logic i_block,
  // Stage outputs
  input wire logic o_pickup,
  input wire logic o_start,
  input wire logic o_alarm,
  input wire logic o_blocked,
  input wire logic o_disp_notify
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Notice soon after a blocked entry
  sequence s_notify;
    ##[0:4] o_disp_notify;
  endsequence
  excl_state_a: assert property (!(o_start && o_blocked))
    else $error("start and blocked together");
  start_tick_a: assert property ($rose(o_start) |->
    $past(i_cycle_tick) && !$past(i_block))
    else $error("start rose off tick or while blocked");
  blk_tick_a: assert property ($rose(o_blocked) |->
    $past(i_cycle_tick)) else $error("blocked rose off tick");
  blk_notify_a: assert property ($rose(o_blocked) |-> s_notify)
    else $error("no notification after blocking");
  notify_pulse_a: assert property (o_disp_notify |=>
    !o_disp_notify) else $error("notification longer than a cycle");
  alarm_clear_a: assert property ($fell(o_start) |=> !o_alarm)
    else $error("alarm stays after start fell");
  alarm_cause_a: assert property ($rose(o_alarm) |->
    o_start && $past(o_start)) else $error("alarm without start");
  pickup_hold_a: assert property ((o_start || o_blocked) |->
    o_pickup) else $error("start or blocked without pickup");
endmodule // dabt_sva

bind dabt_top dabt_sva #(.MS_CYC(MS_CYC)) u_dabt_sva (
  .i_sys_clk, .i_rst, .i_cycle_tick, .i_block, .o_pickup, .o_start,
  .o_alarm, .o_blocked, .o_disp_notify);

//--- test/testbench.sv
// Self-checking bench of the distortion alarm stage.
// Assumes dabt_top with a 20-cycle ms step and the partner model.
`timescale 1ns/1ps
module testbench;
  // ****
  // Signals
  // ****
  logic        clk = 1'b0, rst = 1'b1, err;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h30bbd2f0;
  logic        pready, pslverr, tick, blk, want_blk = 1'b0;
  logic [13:0] l1 = 14'h0, l2 = 14'h0, l3 = 14'h0, ev_l1, ev_l2, ev_l3;
  logic        pick, start, alarm, blocked, ev_v;
  logic [2:0]  ev_id, ev_flt, e_id, ev_sg;
  logic [31:0] ev_t, t_prev = 32'h0;
  logic [2:0]  exp_q[$];
  int          n_fail = 0, check_count = 0, dly;
  wire  [3:0]  st = {pick, blocked, alarm, start};

  dabt_top #(.MS_CYC(20)) u_dabt_top (
    .i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_cycle_tick(tick), .i_block(blk), .i_thd_l1(l1), .i_thd_l2(l2),
    .i_thd_l3(l3), .o_pickup(pick), .o_start(start), .o_alarm(alarm),
    .o_blocked(blocked), .o_disp_notify(), .o_evt_valid(ev_v),
    .o_evt_id(ev_id), .o_evt_time(ev_t), .o_evt_l1(ev_l1),
    .o_evt_l2(ev_l2), .o_evt_l3(ev_l3), .o_evt_fault(ev_flt),
    .o_evt_sg(ev_sg));
  dabt_partner #(.TICK_CYC(10)) u_dabt_partner (
    .i_sys_clk(clk), .i_rst(rst), .i_want_block(want_blk),
    .o_cycle_tick(tick), .o_block(blk));

  // Clock of 5 ns
  initial forever #2.5 clk = ~clk;

  // ****
  // Tasks
  // ****
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // Wait for one state bit, then return on a rising edge
  task automatic wst(input int b, input logic v);
    dly = 0;
    while (st[b] !== v && dly < 3000) begin
      @(negedge clk);
      dly++;
    end
    chk($sformatf("st%0d", b), {31'h0, v}, {31'h0, st[b]});
    @(posedge clk);
  endtask
  task automatic ex(input logic [2:0] id);
    exp_q.push_back(id);
  endtask
  task automatic summarize();
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Event watcher: oldest expected identity against each event
  always @(negedge clk) begin
    if (ev_v === 1'b1) begin
      e_id = (exp_q.size() > 0) ? exp_q.pop_front() : 3'h7;
      chk("ev_id", {29'h0, e_id}, {29'h0, ev_id});
      chk("ev_l1", 32'd1001, {18'h0, ev_l1});
      chk("ev_fault", 32'h1, {29'h0, ev_flt});
      chk("ev_l2", {18'h0, l2}, {18'h0, ev_l2});
      chk("ev_l3", {18'h0, l3}, {18'h0, ev_l3});
      chk("ev_sg", 32'h0, {29'h0, ev_sg});
      chk("ev_time", 32'h1, {31'h0, ev_t >= t_prev});
      t_prev = ev_t;
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end

  // ****
  // Scenarios
  // ****
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdchk("ctrl", dabt_pkg::A_CTRL, dabt_pkg::CTRL_RST);
    rdchk("thr", dabt_pkg::A_THR, {18'h0, dabt_pkg::THR_RST});
    rdchk("dly", dabt_pkg::A_DLY, {13'h0, dabt_pkg::DLY_RST});
    rdchk("unmapped", 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    // Time stamp counter takes a written value and keeps counting
    apb(1'b1, dabt_pkg::A_TIME, 32'h100);
    apb(1'b0, dabt_pkg::A_TIME, 32'h0);
    chk("time", 32'h1, {31'h0, rd - 32'h100 <= 32'h1});
    apb(1'b1, dabt_pkg::A_DLY, 32'h1);
    // Start then alarm after one 5 ms step
    ex(dabt_pkg::EV_START_ON);
    ex(dabt_pkg::EV_ALARM_ON);
    l1 <= 14'd1001;
    wst(0, 1'b1);
    wst(1, 1'b1);
    chk("delay", 32'h1, {31'h0, dly >= 99 && dly <= 104});
    ex(dabt_pkg::EV_START_OFF);
    ex(dabt_pkg::EV_ALARM_OFF);
    l1 <= 14'd0;
    wst(0, 1'b0);
    wst(1, 1'b0);
    // Hysteresis with random other phases, then block during start
    apb(1'b1, dabt_pkg::A_DLY, 32'h4);
    lfsr = lfsr_next(lfsr);
    l2 <= 14'(lfsr % 32'd969);
    lfsr = lfsr_next(lfsr);
    l3 <= 14'(lfsr % 32'd969);
    ex(dabt_pkg::EV_START_ON);
    l1 <= 14'd1001;
    wst(0, 1'b1);
    l1 <= 14'd970;
    repeat (30) @(negedge clk);
    chk("hold", 32'h1, {31'h0, pick});
    ex(dabt_pkg::EV_START_OFF);
    ex(dabt_pkg::EV_BLK_ON);
    want_blk <= 1'b1;
    wst(2, 1'b1);
    wst(0, 1'b0);
    ex(dabt_pkg::EV_START_ON);
    ex(dabt_pkg::EV_BLK_OFF);
    want_blk <= 1'b0;
    wst(0, 1'b1);
    ex(dabt_pkg::EV_START_OFF);
    l1 <= 14'd969;
    wst(3, 1'b0);
    // Blocked at pick-up, then ON-only filter
    ex(dabt_pkg::EV_BLK_ON);
    want_blk <= 1'b1;
    repeat (3) @(posedge clk);
    l1 <= 14'd1001;
    wst(2, 1'b1);
    apb(1'b1, dabt_pkg::A_CTRL, 32'h11);
    ex(dabt_pkg::EV_START_ON);
    want_blk <= 1'b0;
    wst(0, 1'b1);
    l1 <= 14'd0;
    wst(0, 1'b0);
    // Software block in forcing mode, OFF-only filter
    apb(1'b1, dabt_pkg::A_CTRL, 32'h27);
    l1 <= 14'd1001;
    wst(2, 1'b1);
    ex(dabt_pkg::EV_BLK_OFF);
    l1 <= 14'd0;
    wst(2, 1'b0);
    // Disabled path stays quiet
    apb(1'b1, dabt_pkg::A_CTRL, 32'h30);
    l1 <= 14'd1001;
    repeat (40) @(negedge clk);
    chk("disabled", 32'h0, {30'h0, pick, start});
    l1 <= 14'd0;
    // Record store: eight ON records, slot 0 is the first start
    apb(1'b1, dabt_pkg::A_STAT, 32'hffffffff);
    rdchk("stat", dabt_pkg::A_STAT, 32'h800);
    apb(1'b1, dabt_pkg::A_RSEL, 32'h0);
    repeat (2) @(posedge clk);
    rdchk("rinfo", dabt_pkg::A_RINFO, 32'h0);
    rdchk("rl12", dabt_pkg::A_RL12, 32'd1001);
    repeat (20) @(posedge clk);
    chk("ev_left", 32'h0, exp_q.size());
    summarize();
  end
endmodule // testbench
